/* pkg/crb_pkg.sv */
// Constants shared by the count/status capture logic of the timers.
// Assumes an 8-bit I/O data bus with 10-bit port addresses.
package crb_pkg;
    // Counters handled: index 0 = timer 0, 1 = timer 2, 2 = timer 3
    localparam int CRB_NCNT = 3;
    localparam int CRB_CW = 16;

    // I/O port addresses
    localparam logic [9:0] CRB_ADDR_T0 = 10'h040;
    localparam logic [9:0] CRB_ADDR_T2 = 10'h042;
    localparam logic [9:0] CRB_ADDR_T3 = 10'h044;
    localparam logic [9:0] CRB_ADDR_CW_MAIN = 10'h043;
    localparam logic [9:0] CRB_ADDR_CW_AUX = 10'h047;

    // Control word fields
    localparam int CRB_SC_HI = 7;
    localparam int CRB_SC_LO = 6;
    localparam int CRB_RW_HI = 5;
    localparam int CRB_RW_LO = 4;
    localparam int CRB_CTL_HI = 5;
    localparam int CRB_CTL_LO = 0;

    // Read-back command fields
    localparam int CRB_RB_CNT_N = 5;
    localparam int CRB_RB_STS_N = 4;
    localparam int CRB_RB_SEL_T2 = 3;
    localparam int CRB_RB_SEL_T0 = 1;
    localparam int CRB_RB_SEL_T3 = 1;
    localparam int CRB_RB_ZERO = 0;

    // Status byte fields
    localparam int CRB_ST_OUT = 7;
    localparam int CRB_ST_NULL = 6;

    // Select field codes
    localparam logic [1:0] CRB_SC_T0 = 2'h0;
    localparam logic [1:0] CRB_SC_T2 = 2'h2;
    localparam logic [1:0] CRB_SC_T3 = 2'h0;
    localparam logic [1:0] CRB_SC_READBACK = 2'h3;

    // Byte-access codes
    localparam logic [1:0] CRB_RW_LATCH = 2'h0;
    localparam logic [1:0] CRB_RW_LO_ONLY = 2'h1;
    localparam logic [1:0] CRB_RW_HI_ONLY = 2'h2;
    localparam logic [1:0] CRB_RW_LO_HI = 2'h3;

    // Reset values and the unmapped read value
    localparam logic [5:0] CRB_CTL_RST = 6'h30;
    localparam logic [5:0] CRB_CTL_AUX_RST = 6'h10;
    localparam logic CRB_NULL_RST = 1'b1;
    localparam logic [7:0] CRB_RDATA_RST = 8'h00;
    localparam logic [7:0] CRB_RDATA_UNMAPPED = 8'hff;

    // Data port of counter idx
    function automatic logic [9:0] crb_data_port(input int idx);
        crb_data_port = (idx == 0) ? CRB_ADDR_T0 :
                        (idx == 1) ? CRB_ADDR_T2 : CRB_ADDR_T3;
    endfunction
endpackage

/* logic/crb_cmd_decode.sv */
// Control word and data port write decoder for the three timers.
// Assumes a one-cycle write strobe on the same clock as the capture logic.
`timescale 1ns/1ps
module crb_cmd_decode (
    // Host write port
    input wire logic [9:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    // Decoded pulses, one bit per counter, and the new control bits
    output logic [2:0] prog_o,
    output logic [2:0] cnt_cap_o,
    output logic [2:0] sts_cap_o,
    output logic [2:0] data_wr_o,
    output logic [5:0] ctl_new_o
);
    logic cw_main;
    logic cw_aux;
    logic [1:0] sc;
    logic [1:0] rw;
    logic rb_ok;

    assign cw_main = io_wr_i && (io_addr_i == crb_pkg::CRB_ADDR_CW_MAIN);
    assign cw_aux = io_wr_i && (io_addr_i == crb_pkg::CRB_ADDR_CW_AUX);
    assign sc = io_wdata_i[crb_pkg::CRB_SC_HI:crb_pkg::CRB_SC_LO];
    assign rw = io_wdata_i[crb_pkg::CRB_RW_HI:crb_pkg::CRB_RW_LO];
    assign rb_ok = (sc == crb_pkg::CRB_SC_READBACK)
                   && !io_wdata_i[crb_pkg::CRB_RB_ZERO]; // R16

    always_comb begin
        prog_o = 3'h0;
        cnt_cap_o = 3'h0;
        sts_cap_o = 3'h0;
        ctl_new_o = io_wdata_i[crb_pkg::CRB_CTL_HI:crb_pkg::CRB_CTL_LO];
        for (int i = 0; i < crb_pkg::CRB_NCNT; i++) begin
            data_wr_o[i] = io_wr_i
                && (io_addr_i == crb_pkg::crb_data_port(i));
        end
        if (cw_main && rb_ok) begin
            // Counter 1 select bit has no counter behind it
            cnt_cap_o[0] = !io_wdata_i[crb_pkg::CRB_RB_CNT_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T0]; // R06
            cnt_cap_o[1] = !io_wdata_i[crb_pkg::CRB_RB_CNT_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T2]; // R06
            sts_cap_o[0] = !io_wdata_i[crb_pkg::CRB_RB_STS_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T0]; // R08
            sts_cap_o[1] = !io_wdata_i[crb_pkg::CRB_RB_STS_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T2]; // R08
        end else if (cw_main) begin
            for (int i = 0; i < 2; i++) begin
                if (sc == ((i == 0) ? crb_pkg::CRB_SC_T0
                                    : crb_pkg::CRB_SC_T2)) begin
                    cnt_cap_o[i] = (rw == crb_pkg::CRB_RW_LATCH); // R01
                    prog_o[i] = (rw != crb_pkg::CRB_RW_LATCH);
                end
            end
        end else if (cw_aux && rb_ok) begin
            cnt_cap_o[2] = !io_wdata_i[crb_pkg::CRB_RB_CNT_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T3];
            sts_cap_o[2] = !io_wdata_i[crb_pkg::CRB_RB_STS_N]
                && io_wdata_i[crb_pkg::CRB_RB_SEL_T3];
        end else if (cw_aux && sc == crb_pkg::CRB_SC_T3) begin
            // Timer 3 keeps only the byte-access field
            cnt_cap_o[2] = (rw == crb_pkg::CRB_RW_LATCH); // R01
            prog_o[2] = (rw == crb_pkg::CRB_RW_LO_ONLY); // R11
            ctl_new_o = {rw, 4'h0}; // R17
        end
    end
endmodule

/* logic/crb_null_flag.sv */
// Null-count flag of one counter.
// Assumes load_i pulses when the counting element takes a new count.
`timescale 1ns/1ps
module crb_null_flag (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Events
    input wire logic prog_i,
    input wire logic data_wr_i,
    input wire logic two_byte_i,
    input wire logic load_i,
    // Flag
    output logic null_o
);
    logic second_reg;
    logic set_next;

    assign set_next = prog_i || (data_wr_i && (!two_byte_i || second_reg));

    always_ff @(posedge mclk_i) begin
        if (!resetn_i || prog_i) begin
            second_reg <= 1'b0;
        end else if (data_wr_i && two_byte_i) begin
            second_reg <= !second_reg;
        end
    end

    // A load in the same cycle as a final-byte write or reprogram loses: the flag stays set
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            null_o <= crb_pkg::CRB_NULL_RST;
        end else if (set_next) begin
            null_o <= 1'b1; // R14
        end else if (load_i) begin
            null_o <= 1'b0; // R14
        end
    end

    a_null_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        load_i && !set_next |=> !null_o) // R14
        else $error("null flag not cleared by load");
    a_null_second: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        data_wr_i && two_byte_i && !second_reg && !prog_i && !null_o
        |=> !null_o) // R14
        else $error("null flag set on first byte");
endmodule

/* logic/crb_capture_top.sv */
// Count latch, read-back and status capture for timers 0, 2 and 3.
// Assumes the host port and counting elements share mclk_i.
//
// Operation
// (R01) Latch command copies live count to hold
// (R02) Held count frozen until read or reprogram
// (R03) Repeat latch before read is ignored
// (R04) Each counter holds its own capture independently
// (R05) Read-back exposes count, mode, output, null
// (R06) Bit 5 low captures selected counters' counts
// (R07) Read-back count capture acts like latch command
// (R08) Bit 4 low captures status until read
// (R09) Status bits 0-5 mirror control word
// (R10) Status bit 7 shows output level
// (R11) Byte access: low, high, or low-high
// (R12) Host gates clock for unlatched reads
// (R13) Host keeps two-byte reads uninterrupted
// (R14) Null flag set by writes, cleared on load
// (R15) Status read first, then count, then live
// (R16) Read-back when select field is all ones
// (R17) Timer 3 status has zero low bits
`timescale 1ns/1ps
module crb_capture_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Host I/O port
    input wire logic [9:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    // Counting elements
    input wire logic [15:0] ce_count_t0_i,
    input wire logic [15:0] ce_count_t2_i,
    input wire logic [7:0] ce_count_t3_i,
    input wire logic [2:0] ce_out_i,
    input wire logic [2:0] ce_load_i,
    output logic [2:0] null_count_o
);
    localparam int N = crb_pkg::CRB_NCNT;
    localparam int W = crb_pkg::CRB_CW;

    logic [2:0] prog;
    logic [2:0] cnt_cap;
    logic [2:0] sts_cap;
    logic [2:0] data_wr;
    logic [5:0] ctl_new;
    logic [2:0] rd_sel;
    logic [W-1:0] live [N];
    logic [5:0] ctl_reg [N];
    logic [W-1:0] hold_reg [N];
    logic [N-1:0] hold_full_reg;
    logic [7:0] sts_reg [N];
    logic [N-1:0] sts_full_reg;
    logic [N-1:0] rd_hi_reg;
    logic [N-1:0] hold_done;
    logic [7:0] rdata_next;

    // Pick the byte that a read returns for the access field
    function automatic logic [7:0] pick_byte(input logic [W-1:0] val,
                                             input logic [1:0] rw,
                                             input logic hi);
        if (rw == crb_pkg::CRB_RW_HI_ONLY ||
            (rw == crb_pkg::CRB_RW_LO_HI && hi)) begin
            pick_byte = val[15:8]; // R11
        end else begin
            pick_byte = val[7:0]; // R11
        end
    endfunction

    function automatic logic [1:0] rw_of(input logic [5:0] ctl);
        rw_of = ctl[crb_pkg::CRB_RW_HI:crb_pkg::CRB_RW_LO];
    endfunction

    crb_cmd_decode u_decode (
        .io_addr_i(io_addr_i),
        .io_wdata_i(io_wdata_i),
        .io_wr_i(io_wr_i),
        .prog_o(prog),
        .cnt_cap_o(cnt_cap),
        .sts_cap_o(sts_cap),
        .data_wr_o(data_wr),
        .ctl_new_o(ctl_new)
    );

    assign live[0] = ce_count_t0_i;
    assign live[1] = ce_count_t2_i;
    assign live[2] = {8'h00, ce_count_t3_i};

    for (genvar g = 0; g < N; g++) begin : g_cnt
        assign rd_sel[g] = io_rd_i
            && (io_addr_i == crb_pkg::crb_data_port(g));
        // Held count is released by the read of its last byte
        assign hold_done[g] = rd_sel[g] && !sts_full_reg[g]
            && hold_full_reg[g]
            && (rw_of(ctl_reg[g]) != crb_pkg::CRB_RW_LO_HI
                || rd_hi_reg[g]);

        crb_null_flag u_null (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .prog_i(prog[g]),
            .data_wr_i(data_wr[g]),
            .two_byte_i(rw_of(ctl_reg[g]) == crb_pkg::CRB_RW_LO_HI),
            .load_i(ce_load_i[g]),
            .null_o(null_count_o[g])
        );
    end

    // Programmed control bits
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin
            if (!resetn_i) begin
                ctl_reg[i] <= (i == 2) ? crb_pkg::CRB_CTL_AUX_RST
                                       : crb_pkg::CRB_CTL_RST;
            end else if (prog[i]) begin
                ctl_reg[i] <= ctl_new;
            end
        end
    end

    // Count hold latches, one per counter
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin // R04
            if (!resetn_i) begin
                hold_full_reg[i] <= 1'b0;
                hold_reg[i] <= '0;
            end else if (prog[i]) begin
                hold_full_reg[i] <= 1'b0; // R02
            end else if (cnt_cap[i] && !hold_full_reg[i]) begin // R03
                hold_reg[i] <= live[i]; // R01 R07
                hold_full_reg[i] <= 1'b1;
            end else if (hold_done[i]) begin
                hold_full_reg[i] <= 1'b0; // R02
            end
        end
    end

    // Status latches; a repeat capture is ignored like a repeat latch
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin
            if (!resetn_i) begin
                sts_full_reg[i] <= 1'b0;
                sts_reg[i] <= 8'h00;
            end else if (prog[i]) begin
                sts_full_reg[i] <= 1'b0; // R08
            end else if (sts_cap[i] && !sts_full_reg[i]) begin
                sts_reg[i] <= {ce_out_i[i], null_count_o[i],
                               ctl_reg[i]}; // R05 R09 R10 R17
                sts_full_reg[i] <= 1'b1; // R08
            end else if (rd_sel[i]) begin
                sts_full_reg[i] <= 1'b0; // R15
            end
        end
    end

    // Byte pointer for low-then-high reads; status reads leave it alone
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < N; i++) begin
            if (!resetn_i || prog[i]) begin
                rd_hi_reg[i] <= 1'b0;
            end else if (rd_sel[i] && !sts_full_reg[i]
                         && rw_of(ctl_reg[i]) == crb_pkg::CRB_RW_LO_HI) begin
                rd_hi_reg[i] <= !rd_hi_reg[i]; // R11
            end
        end
    end

    // Read data: status first, then held count, then live count
    always_comb begin
        rdata_next = crb_pkg::CRB_RDATA_UNMAPPED;
        for (int i = 0; i < N; i++) begin
            if (rd_sel[i]) begin
                if (sts_full_reg[i]) begin
                    rdata_next = sts_reg[i]; // R15
                end else if (hold_full_reg[i]) begin
                    rdata_next = pick_byte(hold_reg[i], rw_of(ctl_reg[i]),
                                           rd_hi_reg[i]); // R15
                end else begin
                    rdata_next = pick_byte(live[i], rw_of(ctl_reg[i]),
                                           rd_hi_reg[i]);
                end
            end
        end
    end

    // Answer one cycle after the read strobe, data held until next read
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            io_rvalid_o <= 1'b0;
            io_rdata_o <= crb_pkg::CRB_RDATA_RST;
        end else begin
            io_rvalid_o <= io_rd_i;
            if (io_rd_i) begin
                io_rdata_o <= rdata_next;
            end
        end
    end

    a_latch_capture: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R01
        cnt_cap[0] && !hold_full_reg[0] && !prog[0]
        |=> hold_full_reg[0] && hold_reg[0] == $past(live[0]))
        else $error("latch command did not capture count");
    a_latch_frozen: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R02
        hold_full_reg[1] |=> $stable(hold_reg[1]))
        else $error("held count changed");
    a_latch_ignored: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R03
        hold_full_reg[0] && cnt_cap[0] && !prog[0] && !rd_sel[0]
        |=> hold_full_reg[0] ##1 hold_reg[0] == $past(hold_reg[0], 2))
        else $error("repeat latch overwrote held count");
    a_status_first: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R15
        rd_sel[0] && sts_full_reg[0] && hold_full_reg[0]
        |=> io_rvalid_o && io_rdata_o == $past(sts_reg[0])
            && hold_full_reg[0] && !sts_full_reg[0])
        else $error("status not returned first");
    a_status_out: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R10
        sts_cap[1] && !sts_full_reg[1] && !prog[1]
        |=> sts_reg[1][crb_pkg::CRB_ST_OUT] == $past(ce_out_i[1])
            && sts_reg[1][crb_pkg::CRB_ST_NULL] == $past(null_count_o[1]))
        else $error("status output bit wrong");
    a_status_ctl: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R09
        sts_cap[0] && !sts_full_reg[0] && !prog[0]
        |=> sts_reg[0][5:0] == ctl_reg[0])
        else $error("status control bits wrong");
    a_aux_zero: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R17
        sts_full_reg[2] |-> sts_reg[2][3:0] == 4'h0)
        else $error("timer 3 status low bits not zero");
    a_prog_clears: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R02
        prog[1] |=> !hold_full_reg[1] && !sts_full_reg[1]
                    && null_count_o[1] && !rd_hi_reg[1])
        else $error("reprogram did not clear captures");
    a_two_byte_read: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R15
        rd_sel[0] && !sts_full_reg[0] && hold_full_reg[0] && !prog[0]
        && rw_of(ctl_reg[0]) == crb_pkg::CRB_RW_LO_HI && !rd_hi_reg[0]
        |=> hold_full_reg[0] && rd_hi_reg[0]
            && io_rdata_o == $past(hold_reg[0][7:0]))
        else $error("low byte of held count wrong");

    // Host side timing: one answer per read strobe, none otherwise
    a_read_answer: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R05
        io_rd_i |=> io_rvalid_o)
        else $error("read strobe got no answer");
    a_no_answer: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R05
        !io_rd_i |=> !io_rvalid_o)
        else $error("answer without read strobe");
    a_unmapped_read: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R05
        io_rd_i && rd_sel == 3'h0
        |=> io_rdata_o == crb_pkg::CRB_RDATA_UNMAPPED)
        else $error("unmapped read data wrong");

    // Last byte of a held count frees the latch
    a_hold_release: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R02
        hold_done[0] |=> !hold_full_reg[0])
        else $error("held count not released after last byte");

    // A latch on one counter leaves the others alone
    a_indep_latch: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R04
        cnt_cap[1] && !cnt_cap[0] |=> $stable(hold_reg[0]))
        else $error("latch of timer 2 disturbed timer 0");

    // Read-back count capture of the 8-bit timer
    a_rb_count: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R07
        cnt_cap[2] && !hold_full_reg[2] && !prog[2]
        |=> hold_full_reg[2]
            && hold_reg[2][7:0] == $past(ce_count_t3_i))
        else $error("timer 3 count not captured");

    // Unlatched single-byte read returns the live low byte
    a_live_read: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R11
        rd_sel[1] && !sts_full_reg[1] && !hold_full_reg[1] && !prog[1]
        && rw_of(ctl_reg[1]) == crb_pkg::CRB_RW_LO_ONLY
        |=> io_rdata_o == $past(ce_count_t2_i[7:0]))
        else $error("live low byte wrong");

    // Timer 3 status keeps output and null bits like the others
    a_status_aux: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R17
        sts_cap[2] && !sts_full_reg[2] && !prog[2]
        |=> sts_reg[2][crb_pkg::CRB_ST_OUT] == $past(ce_out_i[2])
            && sts_reg[2][crb_pkg::CRB_ST_NULL] == $past(null_count_o[2])
            && sts_reg[2][5:4] == $past(rw_of(ctl_reg[2])))
        else $error("timer 3 status byte wrong");

    // Status read alone never moves the byte pointer
    a_status_ptr: assert property (@(posedge mclk_i)
        disable iff (!resetn_i) // R15
        rd_sel[0] && sts_full_reg[0] && !prog[0]
        |=> $stable(rd_hi_reg[0]))
        else $error("status read moved byte pointer");
endmodule

/* verif/crb_ce_model.sv */
// Stand-in for the counting elements of timers 0, 2 and 3.
// Assumes the bench gates each counter and asks for reloads by pulse.
`timescale 1ns/1ps
module crb_ce_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Bench control
    input wire logic [2:0] gate_i,
    input wire logic [2:0] load_req_i,
    // Counting-element outputs
    output logic [15:0] count_t0_o,
    output logic [15:0] count_t2_o,
    output logic [7:0] count_t3_o,
    output logic [2:0] out_o,
    output logic [2:0] load_o
);
    // Odd steps so that both bytes move between reads
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            count_t0_o <= 16'hc3a5;
            count_t2_o <= 16'h5a3c;
            count_t3_o <= 8'h96;
            out_o <= 3'h0;
            load_o <= 3'h0;
        end else begin
            if (gate_i[0]) begin
                count_t0_o <= count_t0_o - 16'h0107;
            end
            if (gate_i[1]) begin
                count_t2_o <= count_t2_o - 16'h0311;
            end
            if (gate_i[2]) begin
                count_t3_o <= count_t3_o - 8'h03;
            end
            out_o <= out_o ^ (gate_i & {count_t3_o[4], count_t2_o[9],
                                        count_t0_o[8]});
            load_o <= load_req_i;
        end
    end
endmodule

/* verif/test_counter_readback_latch.sv */
// Self-checking bench for the timer count and status capture logic.
// Assumes crb_ce_model stands in for the counting elements.
`timescale 1ns/1ps
module test_counter_readback_latch;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [9:0] io_addr_i = 10'h000;
    logic [7:0] io_wdata_i = 8'h00;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_rdata_o;
    logic io_rvalid_o;
    logic [15:0] ce_count_t0_i;
    logic [15:0] ce_count_t2_i;
    logic [7:0] ce_count_t3_i;
    logic [2:0] ce_out_i;
    logic [2:0] ce_load_i;
    logic [2:0] null_count_o;
    logic [2:0] gate = 3'h7;
    logic [2:0] load_req = 3'h0;
    logic [5:0] ctl [3];
    logic [15:0] snap [3];
    logic [15:0] hold [3];
    logic [2:0] nul;
    logic [2:0] osnap;
    logic [7:0] d;
    logic [7:0] cw;
    int miscompares = 0;
    int n_checks = 0;

    always #20 mclk_i = ~mclk_i;

    crb_capture_top crb_capture_top_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
        .io_rvalid_o(io_rvalid_o), .ce_count_t0_i(ce_count_t0_i),
        .ce_count_t2_i(ce_count_t2_i), .ce_count_t3_i(ce_count_t3_i),
        .ce_out_i(ce_out_i), .ce_load_i(ce_load_i),
        .null_count_o(null_count_o));

    crb_ce_model crb_ce_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .gate_i(gate), .load_req_i(load_req), .count_t0_o(ce_count_t0_i),
        .count_t2_o(ce_count_t2_i), .count_t3_o(ce_count_t3_i),
        .out_o(ce_out_i), .load_o(ce_load_i));

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    function automatic logic [7:0] st(input int idx);
        return {osnap[idx], nul[idx],
                (idx == 2) ? {ctl[2][5:4], 4'h0} : ctl[idx]};
    endfunction

    function automatic logic [7:0] cbyte(input logic [15:0] v,
                                         input logic [1:0] rw,
                                         input logic hi);
        return (rw == 2'h2 || (rw == 2'h3 && hi)) ? v[15:8] : v[7:0];
    endfunction

    // Counts seen by the design at the edge that takes the request
    task automatic take_snap();
        snap[0] = ce_count_t0_i;
        snap[1] = ce_count_t2_i;
        snap[2] = {8'h00, ce_count_t3_i};
        osnap = ce_out_i;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        io_addr_i <= a;
        io_wdata_i <= v;
        io_wr_i <= 1'b1;
        #1;
        take_snap();
        @(posedge mclk_i);
        io_wr_i <= 1'b0;
        // Let the design's flops settle before anyone looks at them
        #1;
    endtask

    task automatic rd(input logic [9:0] a);
        int i;
        @(posedge mclk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge mclk_i);
        io_rd_i <= 1'b0;
        #1;
        i = 0;
        while (io_rvalid_o !== 1'b1 && i < 4) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        if (i == 4) begin
            check(8'h00, 8'h01);
            stop_test();
        end
        check(8'(i), 8'h00);
        d = io_rdata_o;
    endtask

    task automatic rd_count(input int idx, input logic [15:0] v);
        rd(crb_pkg::crb_data_port(idx));
        check(d, cbyte(v, ctl[idx][5:4], 1'b0));
        if (ctl[idx][5:4] == crb_pkg::CRB_RW_LO_HI) begin
            rd(crb_pkg::crb_data_port(idx));
            check(d, v[15:8]);
        end
    endtask

    // Unlatched reads only with the counter stopped
    task automatic live(input int idx);
        gate <= gate & ~(3'h1 << idx);
        repeat (2) @(posedge mclk_i);
        #1;
        take_snap();
        rd_count(idx, snap[idx]);
        gate <= 3'h7;
    endtask

    task automatic prog(input int idx, input logic [1:0] rw);
        cw = {(idx == 1) ? 2'h2 : 2'h0, rw, 4'($urandom)};
        wr(crb_pkg::CRB_ADDR_CW_MAIN, cw);
        ctl[idx] = cw[5:0];
        nul[idx] = 1'b1;
    endtask

    task automatic load(input int idx);
        @(posedge mclk_i);
        load_req <= 3'h1 << idx;
        @(posedge mclk_i);
        load_req <= 3'h0;
        repeat (2) @(posedge mclk_i);
        #1;
        nul[idx] = 1'b0;
    endtask

    initial begin
        cw = 8'($urandom(32'h9caf6e3c));
        ctl[0] = 6'h30;
        ctl[1] = 6'h30;
        ctl[2] = 6'h10;
        nul = 3'h7;
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check(io_rdata_o, 8'h00);
        check({5'h0, null_count_o}, {5'h0, nul});
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'hea);
        rd(crb_pkg::CRB_ADDR_T0);
        check(d, st(0));
        rd(crb_pkg::CRB_ADDR_T2);
        check(d, st(1));
        wr(crb_pkg::CRB_ADDR_CW_AUX, 8'he2);
        rd(crb_pkg::CRB_ADDR_T3);
        check(d, st(2));
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'h00);
        hold[0] = snap[0];
        repeat ($urandom_range(9, 2)) @(posedge mclk_i);
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'h00);
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'h80);
        hold[1] = snap[1];
        wr(crb_pkg::CRB_ADDR_CW_AUX, 8'h00);
        hold[2] = snap[2];
        for (int i = 0; i < 3; i++) begin
            rd_count(i, hold[i]);
        end
        live(0);
        for (int rw = 1; rw < 4; rw++) begin
            for (int idx = 0; idx < 2; idx++) begin
                prog(idx, 2'(rw));
                check({5'h0, null_count_o}, {5'h0, nul});
                wr(crb_pkg::crb_data_port(idx), 8'($urandom));
                if (rw == 3) begin
                    wr(crb_pkg::crb_data_port(idx), 8'($urandom));
                end
                load(idx);
                check({5'h0, null_count_o}, {5'h0, nul});
                wr(crb_pkg::CRB_ADDR_CW_MAIN, (idx == 0) ? 8'hc2 : 8'hc8);
                hold[idx] = snap[idx];
                rd(crb_pkg::crb_data_port(idx));
                check(d, st(idx));
                rd_count(idx, hold[idx]);
                live(idx);
            end
        end
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'hda);
        hold[0] = snap[0];
        hold[1] = snap[1];
        rd_count(0, hold[0]);
        rd_count(1, hold[1]);
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'h00);
        prog(0, 2'h3);
        wr(crb_pkg::CRB_ADDR_CW_MAIN, 8'hc3);
        live(0);
        rd(10'h041);
        check(d, 8'hff);
        stop_test();
    end
endmodule
